// ==== src/arlt_div.sv ====
// Event divider: emits one tick for every DIV input events.
// Assumes ev is a one-cycle pulse synchronous to clk.
`default_nettype none
module arlt_div #(
    parameter int DIV = 8
) (
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic ev, // input event pulse
    output logic tick // one pulse per DIV events
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic wrap;

    assign wrap = ev && (cnt_q == LAST);
    assign cnt_d = wrap ? '0 : (ev ? cnt_q + CW'(1) : cnt_q);
    assign tick = wrap;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : arlt_div
`default_nettype wire

// ==== src/arlt_pkg.sv ====
// Shared constants of the auto-reload timer: register map, field layout, reset values, dividers.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package arlt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h04;
    localparam logic [7:0] OFS_RELOAD_LOW = 8'h08;
    localparam logic [7:0] OFS_RELOAD_HIGH = 8'h0C;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h10;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // timer_ctrl_reg fields
    localparam int CTL_HIGH_OVF = 7;
    localparam int CTL_LOW_OVF = 6;
    localparam int CTL_LOW_IRQ_EN = 5;
    localparam int CTL_CAPTURE_EN = 4;
    localparam int CTL_SPLIT = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_ALT_HI = 1;
    localparam int CTL_ALT_LO = 0;

    // clock_ctrl_reg fields
    localparam int CKC_LOW_FAST = 0;
    localparam int CKC_HIGH_FAST = 1;

    // irq enable and status fields
    localparam int IRQ_TIMER_EN = 0;
    localparam int STS_SYNC_PEND = 0;
    localparam int STS_WAKE = 1;

    // Alternate clock codes
    localparam logic [1:0] ALT_SYS_DIV12 = 2'h0;
    localparam logic [1:0] ALT_EXT_DIV8 = 2'h1;
    localparam logic [1:0] ALT_RESERVED = 2'h2;
    localparam logic [1:0] ALT_LFO = 2'h3;

    // Reset value and all-ones wrap compare values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;

    // Dividers and timing counts
    localparam int DIV_SYS = 12;
    localparam int DIV_SLOW = 8;
    localparam logic [1:0] SYNC_TICKS = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : arlt_pkg
`default_nettype wire

// ==== src/arlt_timer.sv ====
// 16-bit / dual 8-bit auto-reload timer with oscillator capture, AXI4-Lite register slave.
// Assumes ext_clk, lfo_clk, suspend and lfo_div_one are synchronous to clk.
//
// Contract
// RULE1 - 16-bit count, split bit selects dual 8-bit
// RULE2 - 16-bit rollover reloads count, sets high flag
// RULE3 - Timer irq enable requests irq on overflow
// RULE4 - Low-byte enable adds low wrap interrupts
// RULE5 - Split: each byte reloads from own reload
// RULE6 - Split: run bit gates only high byte
// RULE7 - Per-byte fast select else alternate clock code
// RULE8 - Split: each byte wrap sets own flag
// RULE9 - Split irq: high always, low when enabled
// RULE10 - Flags cleared only by software writes
// RULE11 - Slow sources synchronised except in suspend
// RULE12 - Count in suspend; overflow wakes device
// RULE13 - Sync pending flag for three ticks after wake
// RULE14 - Oscillator source counts only with divider one
// RULE15 - Capture copies count to reload, sets flag
// RULE16 - Software avoids split and slow clock capturing
// RULE17 - Run bit gates counting, whole 16 bits
// RULE18 - Low flag set on every low wrap
// RULE19 - Reserved alternate code gives no clock
// RULE20 - Software count write beats increment
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`default_nettype none
module arlt_timer
    import arlt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk, // system clock, 200 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic ext_clk, // external oscillator level
    input wire logic lfo_clk, // low-frequency oscillator level
    input wire logic lfo_div_one, // oscillator divider is set to one
    input wire logic suspend, // device is in suspend
    output logic irq_req, // timer interrupt request, level
    output logic wake_req // wake request from overflow in suspend
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [1:0] clkc_q;
    logic irq_en_q;
    logic [7:0] rl_l_q;
    logic [7:0] rl_h_q;
    logic [7:0] rl_l_d;
    logic [7:0] rl_h_d;
    logic [7:0] cnt_l_q;
    logic [7:0] cnt_h_q;
    logic [7:0] cnt_l_d;
    logic [7:0] cnt_h_d;
    logic [2:0] ext_sync_q;
    logic [2:0] lfo_sync_q;
    logic ext_raw_q;
    logic lfo_raw_q;
    logic suspend_q;
    logic wake_q;
    logic pend_q;
    logic [1:0] pend_cnt_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Slow clock edges: synchronised normally, direct path while suspended
    wire ext_edge_sync = ext_sync_q[1] & ~ext_sync_q[2];
    wire ext_edge_raw = ext_clk & ~ext_raw_q;
    wire ext_ev = suspend ? ext_edge_raw : ext_edge_sync; // see RULE11
    wire lfo_rise_sync = lfo_sync_q[1] & ~lfo_sync_q[2];
    wire lfo_rise_raw = lfo_clk & ~lfo_raw_q;
    wire lfo_fall_sync = ~lfo_sync_q[1] & lfo_sync_q[2];
    wire lfo_fall_raw = ~lfo_clk & lfo_raw_q;
    wire lfo_ev = suspend ? lfo_rise_raw : lfo_rise_sync; // see RULE11
    wire lfo_fall = suspend ? lfo_fall_raw : lfo_fall_sync;
    // The oscillator path is dead unless its own divider is one
    wire lfo_ev_ok = lfo_ev & lfo_div_one; // see RULE14

    logic sys12_tick;
    logic ext8_tick;
    logic lfo8_tick;

    arlt_div #(.DIV(DIV_SYS)) u_div_sys (
        .clk(clk),
        .srst(srst),
        .ev(1'b1),
        .tick(sys12_tick)
    );
    arlt_div #(.DIV(DIV_SLOW)) u_div_ext (
        .clk(clk),
        .srst(srst),
        .ev(ext_ev),
        .tick(ext8_tick)
    );
    arlt_div #(.DIV(DIV_SLOW)) u_div_lfo (
        .clk(clk),
        .srst(srst),
        .ev(lfo_ev_ok),
        .tick(lfo8_tick)
    );

    wire [1:0] alt_sel = ctrl_q[CTL_ALT_HI:CTL_ALT_LO];
    wire split = ctrl_q[CTL_SPLIT]; // see RULE1
    wire run = ctrl_q[CTL_RUN];
    wire low_irq_en = ctrl_q[CTL_LOW_IRQ_EN];
    wire cap_en = ctrl_q[CTL_CAPTURE_EN];
    wire alt_tick = (alt_sel == ALT_SYS_DIV12) ? sys12_tick :
                    (alt_sel == ALT_EXT_DIV8) ? ext8_tick :
                    (alt_sel == ALT_LFO) ? lfo8_tick : 1'b0; // see RULE7, RULE19
    wire tick_l = clkc_q[CKC_LOW_FAST] ? 1'b1 : alt_tick; // see RULE7
    wire tick_h = clkc_q[CKC_HIGH_FAST] ? 1'b1 : alt_tick; // see RULE7

    // In 16-bit mode the low-byte clock drives the whole count
    wire inc_l = split ? tick_l : (run & tick_l); // see RULE6, RULE17
    wire inc_h = run & tick_h; // see RULE6
    wire [15:0] cnt16 = {cnt_h_q, cnt_l_q};
    wire [15:0] rl16 = {rl_h_q, rl_l_q};
    wire [15:0] cnt16_inc = cnt16 + 16'h0001;
    wire full_wrap = ~split & inc_l & (cnt16 == WORD_ALL_ONES); // see RULE2
    wire low_wrap = inc_l & (cnt_l_q == BYTE_ALL_ONES); // see RULE18
    wire high_wrap_split = split & inc_h & (cnt_h_q == BYTE_ALL_ONES); // see RULE8
    wire high_wrap = full_wrap | high_wrap_split;
    wire capture = cap_en & lfo_fall; // see RULE15

    // Register bus decode
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    wire rd_go = s_axi_arvalid & ~rvalid_q;
    wire wr_lane = s_axi_wstrb[0];
    wire [7:0] wbyte = s_axi_wdata[7:0];
    wire [7:0] waddr = 8'(s_axi_awaddr);
    wire [7:0] raddr = 8'(s_axi_araddr);
    wire wr_ctrl = wr_go & wr_lane & (waddr == OFS_TIMER_CTRL);
    wire wr_clkc = wr_go & wr_lane & (waddr == OFS_CLOCK_CTRL);
    wire wr_rl_l = wr_go & wr_lane & (waddr == OFS_RELOAD_LOW);
    wire wr_rl_h = wr_go & wr_lane & (waddr == OFS_RELOAD_HIGH);
    wire wr_cnt_l = wr_go & wr_lane & (waddr == OFS_COUNT_LOW);
    wire wr_cnt_h = wr_go & wr_lane & (waddr == OFS_COUNT_HIGH);
    wire wr_irq = wr_go & wr_lane & (waddr == OFS_IRQ_EN);
    wire wr_hit = (waddr == OFS_TIMER_CTRL) || (waddr == OFS_CLOCK_CTRL) ||
                  (waddr == OFS_RELOAD_LOW) || (waddr == OFS_RELOAD_HIGH) ||
                  (waddr == OFS_COUNT_LOW) || (waddr == OFS_COUNT_HIGH) ||
                  (waddr == OFS_IRQ_EN) || (waddr == OFS_STATUS);
    wire wr_addr_ok = wr_hit && (s_axi_awaddr == ADDR_W'(waddr));

    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = (s_axi_araddr == ADDR_W'(raddr));
        if (raddr == OFS_TIMER_CTRL) begin
            rd_val[7:0] = ctrl_q;
        end else if (raddr == OFS_CLOCK_CTRL) begin
            rd_val[1:0] = clkc_q;
        end else if (raddr == OFS_RELOAD_LOW) begin
            rd_val[7:0] = rl_l_q;
        end else if (raddr == OFS_RELOAD_HIGH) begin
            rd_val[7:0] = rl_h_q;
        end else if (raddr == OFS_COUNT_LOW) begin
            rd_val[7:0] = cnt_l_q;
        end else if (raddr == OFS_COUNT_HIGH) begin
            rd_val[7:0] = cnt_h_q;
        end else if (raddr == OFS_IRQ_EN) begin
            rd_val[IRQ_TIMER_EN] = irq_en_q;
        end else if (raddr == OFS_STATUS) begin
            rd_val[STS_SYNC_PEND] = pend_q;
            rd_val[STS_WAKE] = wake_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Flags: software write first, hardware set on top so a coincident event survives
    always_comb begin
        ctrl_d = wr_ctrl ? wbyte : ctrl_q; // see RULE10
        ctrl_d[CTL_HIGH_OVF] = ctrl_d[CTL_HIGH_OVF] | high_wrap | capture; // see RULE2, RULE8
        ctrl_d[CTL_LOW_OVF] = ctrl_d[CTL_LOW_OVF] | low_wrap; // see RULE18, RULE8
    end

    // Count next value; a software byte write overrides the increment of that byte
    always_comb begin
        cnt_l_d = cnt_l_q;
        cnt_h_d = cnt_h_q;
        if (!split) begin
            if (inc_l) begin
                {cnt_h_d, cnt_l_d} = full_wrap ? rl16 : cnt16_inc; // see RULE2
            end
        end else begin
            if (inc_l) begin
                cnt_l_d = low_wrap ? rl_l_q : cnt_l_q + 8'h01; // see RULE5
            end
            if (inc_h) begin
                cnt_h_d = high_wrap_split ? rl_h_q : cnt_h_q + 8'h01; // see RULE5
            end
        end
        if (wr_cnt_l) begin
            cnt_l_d = wbyte; // see RULE20
        end
        if (wr_cnt_h) begin
            cnt_h_d = wbyte; // see RULE20
        end
    end

    // Capture is a hardware event and outranks a software reload write
    assign rl_l_d = capture ? cnt_l_q : (wr_rl_l ? wbyte : rl_l_q); // see RULE15
    assign rl_h_d = capture ? cnt_h_q : (wr_rl_h ? wbyte : rl_h_q); // see RULE15

    // Suspend exit bookkeeping
    wire susp_exit = suspend_q & ~suspend;
    wire pend_set = susp_exit & ~wake_q; // see RULE13
    wire pend_done = pend_q & tick_l & (pend_cnt_q == SYNC_TICKS - 2'h1);

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= RST_BYTE;
            clkc_q <= 2'h0;
            irq_en_q <= 1'b0;
            rl_l_q <= RST_BYTE;
            rl_h_q <= RST_BYTE;
            cnt_l_q <= RST_BYTE;
            cnt_h_q <= RST_BYTE;
        end else begin
            ctrl_q <= ctrl_d;
            clkc_q <= wr_clkc ? wbyte[1:0] : clkc_q;
            irq_en_q <= wr_irq ? wbyte[IRQ_TIMER_EN] : irq_en_q;
            rl_l_q <= rl_l_d;
            rl_h_q <= rl_h_d;
            cnt_l_q <= cnt_l_d;
            cnt_h_q <= cnt_h_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_sync_q <= 3'h0;
            lfo_sync_q <= 3'h0;
            ext_raw_q <= 1'b0;
            lfo_raw_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_clk}; // see RULE11
            lfo_sync_q <= {lfo_sync_q[1:0], lfo_clk}; // see RULE11
            ext_raw_q <= ext_clk;
            lfo_raw_q <= lfo_clk;
        end
    end

    // Wake is held through suspend; it also tells the exit whether the timer caused it
    always_ff @(posedge clk) begin
        if (srst) begin
            suspend_q <= 1'b0;
            wake_q <= 1'b0;
            pend_q <= 1'b0;
            pend_cnt_q <= 2'h0;
        end else begin
            suspend_q <= suspend;
            wake_q <= suspend & (wake_q | high_wrap); // see RULE12
            if (pend_set) begin
                pend_q <= 1'b1; // see RULE13
                pend_cnt_q <= 2'h0;
            end else if (pend_done) begin
                pend_q <= 1'b0;
                pend_cnt_q <= 2'h0;
            end else if (pend_q && tick_l) begin
                pend_cnt_q <= pend_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_addr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_ok ? rd_val : 32'h0000_0000;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Software finds the cause by reading both flags
    assign irq_req = irq_en_q & (ctrl_q[CTL_HIGH_OVF] |
                     (low_irq_en & ctrl_q[CTL_LOW_OVF])); // see RULE3, RULE4, RULE9
    assign wake_req = wake_q; // see RULE12
endmodule : arlt_timer
`default_nettype wire

// ==== test/arlt_timer_assertions.sv ====
// Checker for the timer's bus handshakes, interrupt and wake outputs.
// Assumes one clock domain; sees only the top module's ports.
`default_nettype none
module arlt_timer_chk (
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic suspend, // suspend
    input wire logic irq_req, // interrupt
    input wire logic wake_req // wake
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence wr_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    logic wr_take;
    assign wr_take = s_axi_awvalid && s_axi_awready;
    wr_answer_a: assert property (wr_take_s |=> s_axi_bvalid)
        else $error("write not answered");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
        else $error("read not answered");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    flag_clear_a: assert property ($fell(irq_req) |-> $past(wr_take))
        else $error("interrupt cleared without a write");
    wake_drop_a: assert property (!suspend |=> !wake_req)
        else $error("wake held outside suspend");
    wake_cause_a: assert property ($rose(wake_req) |-> $past(suspend))
        else $error("wake raised outside suspend");
endmodule : arlt_timer_chk
bind arlt_timer arlt_timer_chk chk_i (.clk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .suspend, .irq_req, .wake_req);
`default_nettype wire

// ==== test/arlt_timer_bench.sv ====
// Self-checking bench for the auto-reload timer over its AXI4-Lite slave.
// Assumes the slave answers within a few cycles; every wait is bounded.
`default_nettype none
module arlt_timer_bench
    import arlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic ext_clk, lfo_clk, lfo_div_one, suspend, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq_req, wake_req;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int checks = 0;
    int err_count = 0;
    arlt_timer dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk, .lfo_clk,
        .lfo_div_one, .suspend, .irq_req, .wake_req);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("TB: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // Bounded wait for a level sampled on a rising edge
    task automatic until_hi(ref logic s);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_count++;
            end_sim();
        end
    endtask : until_hi
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        until_hi(s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        until_hi(s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(r));
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        until_hi(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        until_hi(s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(r));
        @(posedge clk);
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(v, e);
    endtask : rdc
    // Whole periods only, so the divide-by-8 stays phase aligned between scenarios
    task automatic pulses(input bit use_lfo, input int n);
        for (int i = 0; i < n; i++) begin
            if (use_lfo) begin
                lfo_clk <= 1'b1;
            end else begin
                ext_clk <= 1'b1;
            end
            repeat (4) @(posedge clk);
            lfo_clk <= 1'b0;
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : pulses
    task automatic t_regs;
        logic [31:0] v;
        rdc(OFS_TIMER_CTRL, 32'h0);
        rd(8'h20, v, RESP_SLVERR);
        chk(v, 32'h0);
        wr(8'h20, 8'h55, RESP_SLVERR);
        wr(OFS_RELOAD_LOW, 8'hA5);
        rdc(OFS_RELOAD_LOW, 32'hA5);
        $display("TB: registers done");
    endtask : t_regs
    task automatic t_wrap16;
        logic [31:0] a, b;
        wr(OFS_IRQ_EN, 8'h01);
        wr(OFS_CLOCK_CTRL, 8'h01);
        wr(OFS_RELOAD_LOW, 8'h34);
        wr(OFS_RELOAD_HIGH, 8'h12);
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_COUNT_LOW, 8'hF0);
        wr(OFS_TIMER_CTRL, 8'h04);
        repeat (20) @(posedge clk);
        rdc(OFS_TIMER_CTRL, 32'hC4);
        chk(32'(irq_req), 32'h1);
        wr(OFS_TIMER_CTRL, 8'h00);
        chk(32'(irq_req), 32'h0);
        rdc(OFS_COUNT_HIGH, 32'h12);
        rd(OFS_COUNT_LOW, a);
        rd(OFS_COUNT_LOW, b);
        chk(b, a);
        wr(OFS_COUNT_LOW, 8'hF0);
        wr(OFS_TIMER_CTRL, 8'h24);
        repeat (20) @(posedge clk);
        chk(32'(irq_req), 32'h1);
        rdc(OFS_TIMER_CTRL, 32'h64);
        wr(OFS_TIMER_CTRL, 8'h00);
        $display("TB: 16-bit done");
    endtask : t_wrap16
    task automatic t_split;
        logic [31:0] v;
        wr(OFS_RELOAD_LOW, 8'hF8);
        wr(OFS_RELOAD_HIGH, 8'hF8);
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_COUNT_LOW, 8'hF8);
        wr(OFS_TIMER_CTRL, 8'h28);
        repeat (20) @(posedge clk);
        rdc(OFS_TIMER_CTRL, 32'h68);
        chk(32'(irq_req), 32'h1);
        rdc(OFS_COUNT_HIGH, 32'hFF);
        rd(OFS_COUNT_LOW, v);
        chk(32'(v[7:3]), 32'h1F);
        // High byte runs on the divide-by-12 source here
        wr(OFS_TIMER_CTRL, 8'h0C);
        repeat (30) @(posedge clk);
        rdc(OFS_TIMER_CTRL, 32'hCC);
        chk(32'(irq_req), 32'h1);
        // Low byte runs every clock: the written value must win over the increment
        wr(OFS_COUNT_LOW, 8'hF0);
        rd(OFS_COUNT_LOW, v);
        chk(32'(v[7:3]), 32'h1E);
        wr(OFS_TIMER_CTRL, 8'h08);
        // Two or three divide-by-12 ticks after the first wrap: F8 to FB, never FF
        rd(OFS_COUNT_HIGH, v);
        chk(32'(v[7:2]), 32'h3E);
        wr(OFS_TIMER_CTRL, 8'h00);
        $display("TB: split done");
    endtask : t_split
    task automatic t_clock;
        wr(OFS_CLOCK_CTRL, 8'h00);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_TIMER_CTRL, 8'h05);
        pulses(1'b0, 16);
        wr(OFS_TIMER_CTRL, 8'h06);
        rdc(OFS_COUNT_LOW, 32'h02);
        pulses(1'b0, 16);
        rdc(OFS_COUNT_LOW, 32'h02);
        wr(OFS_TIMER_CTRL, 8'h07);
        lfo_div_one <= 1'b0;
        pulses(1'b1, 8);
        rdc(OFS_COUNT_LOW, 32'h02);
        lfo_div_one <= 1'b1;
        pulses(1'b1, 8);
        wr(OFS_TIMER_CTRL, 8'h00);
        rdc(OFS_COUNT_LOW, 32'h03);
        $display("TB: clock select done");
    endtask : t_clock
    task automatic t_capture;
        wr(OFS_CLOCK_CTRL, 8'h01);
        wr(OFS_COUNT_HIGH, 8'h00);
        wr(OFS_TIMER_CTRL, 8'h14);
        pulses(1'b1, 1);
        rdc(OFS_TIMER_CTRL, 32'h94);
        wr(OFS_TIMER_CTRL, 8'h00);
        rdc(OFS_RELOAD_HIGH, 32'h00);
        $display("TB: capture done");
    endtask : t_capture
    task automatic t_wake;
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_COUNT_LOW, 8'hF0);
        suspend <= 1'b1;
        wr(OFS_TIMER_CTRL, 8'h04);
        until_hi(wake_req);
        chk(32'(wake_req), 32'h1);
        rdc(OFS_STATUS, 32'h02);
        suspend <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(wake_req), 32'h0);
        wr(OFS_TIMER_CTRL, 8'h00);
        $display("TB: wake done");
    endtask : t_wake
    // Leaving suspend without a timer wake; divide-by-12 ticks keep the flag up long enough
    task automatic t_sync;
        wr(OFS_CLOCK_CTRL, 8'h00);
        suspend <= 1'b1;
        repeat (2) @(posedge clk);
        suspend <= 1'b0;
        @(posedge clk);
        rdc(OFS_STATUS, 32'h01);
        repeat (40) @(posedge clk);
        rdc(OFS_STATUS, 32'h00);
        $display("TB: sync pending done");
    endtask : t_sync
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {ext_clk, lfo_clk, suspend} = '0;
        lfo_div_one = 1'b1;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        srst = 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_wrap16();
        t_split();
        t_clock();
        t_capture();
        t_wake();
        t_sync();
        end_sim();
    end
endmodule : arlt_timer_bench
`default_nettype wire
